// File: serdes_pkg.sv
// constants, tables and shared coding functions for the parallel word port
package serdes_pkg;
   // ---------------------------------------------------------------
   // widths and timing
   // ---------------------------------------------------------------
   localparam int WORD_W = 16;
   localparam int SYM_W = 20;
   localparam int BUF_DEPTH = 2;
   localparam int CLK_PERIOD_NS = 8;
   localparam int POR_TIME_NS = 200000;
   // least time, rounded up to whole cycles
   localparam int POR_CYCLES = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PRBS_LOCK_WORDS = 4;
   localparam logic [4:0] PREEMPH_LOW_PCT = 5'h05;
   localparam logic [4:0] PREEMPH_HIGH_PCT = 5'h14;
   localparam logic [7:0] COMMA_BYTE = 8'hbc;
   localparam logic [14:0] PRBS_SEED = 15'h7fff;
   localparam logic [4:0] K28_IDX = 5'h1c;

   // ---------------------------------------------------------------
   // 8b/10b sub-block tables, negative running disparity form
   // ---------------------------------------------------------------
   localparam logic [5:0] T6 [32] = '{
      6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
      6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17,
      6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a,
      6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
   localparam logic [3:0] T4 [8] = '{
      4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};
   localparam logic [5:0] K28_6B = 6'h0f;
   localparam logic [3:0] ALT7_4B = 4'h7;

   typedef enum logic [1:0] {
      ST_OFF = 2'b00,
      ST_POR = 2'b01,
      ST_RUN = 2'b10
   } dev_state_t;

   // encode one byte; returns {rd_out, abcdei, fghj}
   function automatic logic [10:0] enc8b10b(input logic [7:0] d, input logic k,
                                            input logic rd);
      logic [5:0] c6;
      logic [3:0] c4;
      logic rd1;
      logic [4:0] x;
      logic [2:0] y;
      x = d[4:0];
      y = d[7:5];
      c6 = (k && x == K28_IDX) ? K28_6B : T6[x];
      if (rd && ($countones(c6) != 3 || c6 == 6'h38)) c6 = ~c6;
      rd1 = ($countones(c6) != 3) ? ~rd : rd;
      c4 = T4[y];
      // alternate 7 avoids a run of five equal bits across the sub-blocks
      if (y == 3'h7 && (k || (!rd1 && (x == 5'h11 || x == 5'h12 || x == 5'h14))
          || (rd1 && (x == 5'h0b || x == 5'h0d || x == 5'h0e)))) c4 = ALT7_4B;
      if (rd1 && ($countones(c4) != 2 || c4 == 4'hc)) c4 = ~c4;
      if (k && !rd1 && $countones(c4) == 2) c4 = ~c4;
      return {(($countones(c4) != 2) ? ~rd1 : rd1), c6, c4};
   endfunction

   // decode one symbol; returns {valid, k, byte}; data codes win over control
   function automatic logic [9:0] dec8b10b(input logic [9:0] s);
      logic [9:0] r;
      logic [10:0] e0;
      logic [10:0] e1;
      r = 10'h000;
      for (int i = 511; i >= 0; i--) begin
         e0 = enc8b10b(i[7:0], i[8], 1'b0);
         e1 = enc8b10b(i[7:0], i[8], 1'b1);
         if (e0[9:0] == s || e1[9:0] == s) r = {1'b1, i[8], i[7:0]};
      end
      return r;
   endfunction

   // next sixteen bits of x^15+x^14+1; returns {state, word}
   function automatic logic [30:0] prbs_word(input logic [14:0] s);
      logic [15:0] w;
      logic b;
      w = 16'h0000;
      for (int i = 0; i < 16; i++) begin
         b = s[14] ^ s[13];
         w[i] = b;
         s = {s[13:0], b};
      end
      return {s, w};
   endfunction

   // generator state that would have produced this word last
   function automatic logic [14:0] prbs_seed(input logic [15:0] w);
      logic [14:0] s;
      s = 15'h0000;
      for (int i = 0; i < 15; i++) s[i] = w[15 - i];
      return s;
   endfunction
endpackage

// File: serdes_link_if.sv
// parallel-side signals between the transceiver and the protocol device
interface serdes_link_if;
   logic [15:0] tx_word;
   logic tx_k_sel_lo;
   logic tx_k_sel_hi;
   logic ref_clk_run;
   logic enable;
   logic rx_ref_lock_n;
   logic prbs_check_en;
   logic preemph_sel;
   logic factory_test_pin;
   logic rx_ready;
   logic [15:0] rx_word;
   logic rx_word_oe;
   logic rx_k_flag_lo;
   logic rx_k_flag_lo_oe;
   logic rx_k_flag_hi;
   logic rx_k_flag_hi_oe;
   logic rx_word_clk;
   logic rx_word_clk_oe;

   modport dev (
      input tx_word, tx_k_sel_lo, tx_k_sel_hi, ref_clk_run, enable, rx_ref_lock_n,
      input prbs_check_en, preemph_sel, factory_test_pin, rx_ready,
      output rx_word, rx_word_oe, rx_k_flag_lo, rx_k_flag_lo_oe, rx_k_flag_hi,
      output rx_k_flag_hi_oe, rx_word_clk, rx_word_clk_oe
   );
   modport host (
      output tx_word, tx_k_sel_lo, tx_k_sel_hi, ref_clk_run, enable, rx_ref_lock_n,
      output prbs_check_en, preemph_sel, factory_test_pin, rx_ready,
      input rx_word, rx_word_oe, rx_k_flag_lo, rx_k_flag_lo_oe, rx_k_flag_hi,
      input rx_k_flag_hi_oe, rx_word_clk, rx_word_clk_oe
   );
endinterface

// File: serdes_word_port_dev.sv
// transceiver end of the parallel word port: coding, receive buffer, word clock
// ---------------------------------------------------------------
// Overview of operation
// - select 5% or 20% pre-emphasis by pin
// - PRBS mode: low K flag shows pass
// - low K flag marks control low byte
// - high K flag marks control high byte
// - weak serial input forces word, flags high
// - disabled: high flag reports signal loss, low=lost
// - word clock is bit clock over twenty; here one cycle high per popped word, at most half the reference clock
// - word clock stays low during power-on reset
// - receive word stable at word clock rise
// - receive word floats during power-on reset
// - low byte sent as K or D
// - high byte sent as K or D
// - transmit word taken each reference clock rise
// - host reference clock 80 to 135 MHz
// - disabled: serial out, word, low flag float
// - host keeps reference clock during shutdown
// - host may lock receiver for transmit only
// - factory test pin held low always
// - lock low floats receive side outputs
// - enable rise runs power-on reset first
// ---------------------------------------------------------------
module serdes_word_port_dev #(
   parameter int POR_CYCLES = serdes_pkg::POR_CYCLES,
   parameter int BUF_DEPTH = serdes_pkg::BUF_DEPTH
) (
   // clock, enable, reset
   input wire logic CLK,
   input wire logic CE,
   input wire logic RST,
   // parallel side towards the protocol device
   serdes_link_if.dev LINK,
   // serial transmit symbols, two 10-bit symbols per word, low byte in [9:0]
   output logic [19:0] SERIAL_OUT,
   output logic SERIAL_OUT_VALID,
   output logic SERIAL_OUT_OE,
   output logic [4:0] PREEMPH_PCT,
   // serial receive symbols and amplitude detector
   input wire logic [19:0] SERIAL_IN,
   input wire logic SERIAL_IN_VALID,
   output logic SERIAL_IN_READY,
   input wire logic SIGNAL_ABOVE_MIN
);
   localparam int PW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;

   serdes_pkg::dev_state_t state_reg;
   logic [31:0] por_cnt_reg;
   logic en_q_reg;
   logic rd_hi_reg;
   logic [17:0] buf_mem [BUF_DEPTH];
   logic [PW-1:0] wr_ptr_reg;
   logic [PW-1:0] rd_ptr_reg;
   logic [PW:0] count_reg;
   logic [PW:0] count_next;
   logic [17:0] shown_reg;
   logic pulse_reg;
   logic [2:0] prbs_run_reg;
   logic prbs_pass_reg;
   logic [10:0] enc_lo;
   logic [10:0] enc_hi;
   logic [9:0] dec_lo;
   logic [9:0] dec_hi;
   logic rx_active;
   logic push;
   logic pop;
   logic [30:0] prbs_pred;

   // ---------------------------------------------------------------
   // power state
   // ---------------------------------------------------------------
   // enable rise always passes through reset before words move
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         state_reg <= serdes_pkg::ST_OFF;
         por_cnt_reg <= 32'h0;
         en_q_reg <= 1'b0;
      end else if (CE) begin
         en_q_reg <= LINK.enable;
         case (state_reg)
            serdes_pkg::ST_OFF: begin
               if (LINK.enable && !en_q_reg) begin
                  state_reg <= serdes_pkg::ST_POR;
                  por_cnt_reg <= 32'h0;
               end
            end
            serdes_pkg::ST_POR: begin
               if (!LINK.enable) state_reg <= serdes_pkg::ST_OFF;
               else if (por_cnt_reg >= 32'(POR_CYCLES - 1)) state_reg <= serdes_pkg::ST_RUN;
               else por_cnt_reg <= por_cnt_reg + 32'h1;
            end
            serdes_pkg::ST_RUN: begin
               if (!LINK.enable) state_reg <= serdes_pkg::ST_OFF;
            end
            default: state_reg <= serdes_pkg::ST_OFF;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // transmit path
   // ---------------------------------------------------------------
   // the high byte continues the disparity left by the low byte
   assign enc_lo = serdes_pkg::enc8b10b(LINK.tx_word[7:0], LINK.tx_k_sel_lo, rd_hi_reg);
   assign enc_hi = serdes_pkg::enc8b10b(LINK.tx_word[15:8], LINK.tx_k_sel_hi, enc_lo[10]);

   // word and selects registered on every reference clock rise in the run state
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         SERIAL_OUT <= 20'h00000;
         SERIAL_OUT_VALID <= 1'b0;
         SERIAL_OUT_OE <= 1'b0;
         PREEMPH_PCT <= serdes_pkg::PREEMPH_LOW_PCT;
         rd_hi_reg <= 1'b0;
      end else if (CE) begin
         SERIAL_OUT_OE <= LINK.enable;
         // an open pin reads low, so the weaker setting is the default
         PREEMPH_PCT <= LINK.preemph_sel ? serdes_pkg::PREEMPH_HIGH_PCT
                                         : serdes_pkg::PREEMPH_LOW_PCT;
         SERIAL_OUT_VALID <= (state_reg == serdes_pkg::ST_RUN);
         if (state_reg == serdes_pkg::ST_RUN) begin
            SERIAL_OUT <= {enc_hi[9:0], enc_lo[9:0]};
            rd_hi_reg <= enc_hi[10];
         end else begin
            rd_hi_reg <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // receive buffer
   // ---------------------------------------------------------------
   // a locked or disabled receiver ignores the line, so the stream is swallowed;
   // enable is read directly so the outputs float before the state catches up
   assign rx_active = (state_reg == serdes_pkg::ST_RUN) && LINK.enable
                      && LINK.rx_ref_lock_n;
   assign dec_lo = serdes_pkg::dec8b10b(SERIAL_IN[9:0]);
   assign dec_hi = serdes_pkg::dec8b10b(SERIAL_IN[19:10]);
   assign push = SERIAL_IN_VALID && SERIAL_IN_READY && rx_active;
   assign pop = (count_reg != '0) && !pulse_reg && LINK.rx_ready && rx_active;
   assign count_next = rx_active ? count_reg + (PW + 1)'(push) - (PW + 1)'(pop) : '0;

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
         SERIAL_IN_READY <= 1'b0;
      end else if (CE) begin
         count_reg <= count_next;
         // ready is held from the next count so that a push never overflows
         SERIAL_IN_READY <= !rx_active || (count_next < (PW + 1)'(BUF_DEPTH));
         if (!rx_active) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
         end else begin
            if (push) wr_ptr_reg <= (wr_ptr_reg == PW'(BUF_DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
            if (pop) rd_ptr_reg <= (rd_ptr_reg == PW'(BUF_DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
         end
      end
   end

   // storage has no reset; only counted entries are ever read
   always_ff @(posedge CLK) begin
      if (CE && push) buf_mem[wr_ptr_reg] <= {dec_hi[8], dec_lo[8], dec_hi[7:0], dec_lo[7:0]};
   end

   // ---------------------------------------------------------------
   // word clock and prbs checker
   // ---------------------------------------------------------------
   assign prbs_pred = serdes_pkg::prbs_word(serdes_pkg::prbs_seed(shown_reg[15:0]));

   // one popped word becomes one word-clock period of at least two cycles
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         shown_reg <= 18'h00000;
         pulse_reg <= 1'b0;
         prbs_run_reg <= 3'h0;
         prbs_pass_reg <= 1'b0;
      end else if (CE) begin
         pulse_reg <= pop;
         if (pop) begin
            shown_reg <= buf_mem[rd_ptr_reg];
            // each word is checked against the sequence implied by the last one
            if (buf_mem[rd_ptr_reg][15:0] == prbs_pred[15:0]) begin
               if (prbs_run_reg != 3'(serdes_pkg::PRBS_LOCK_WORDS)) begin
                  prbs_run_reg <= prbs_run_reg + 3'h1;
               end
            end else begin
               prbs_run_reg <= 3'h0;
            end
         end
         if (!rx_active) prbs_run_reg <= 3'h0;
         prbs_pass_reg <= (prbs_run_reg == 3'(serdes_pkg::PRBS_LOCK_WORDS));
      end
   end

   // ---------------------------------------------------------------
   // parallel outputs and their enables
   // ---------------------------------------------------------------
   // data changes as the clock rises and holds until the next rise; the clock stays high one cycle
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         LINK.rx_word <= 16'h0000;
         LINK.rx_k_flag_lo <= 1'b0;
         LINK.rx_k_flag_hi <= 1'b0;
         LINK.rx_word_clk <= 1'b0;
         LINK.rx_word_oe <= 1'b0;
         LINK.rx_word_clk_oe <= 1'b0;
         LINK.rx_k_flag_lo_oe <= 1'b0;
         LINK.rx_k_flag_hi_oe <= 1'b0;
      end else if (CE) begin
         LINK.rx_word_clk <= rx_active && pulse_reg;
         LINK.rx_word_oe <= rx_active;
         LINK.rx_word_clk_oe <= LINK.enable && LINK.rx_ref_lock_n;
         LINK.rx_k_flag_lo_oe <= LINK.enable && LINK.rx_ref_lock_n;
         // loss report in shutdown needs the host's reference clock running
         LINK.rx_k_flag_hi_oe <= LINK.enable ? LINK.rx_ref_lock_n : LINK.ref_clk_run;
         if (!LINK.enable) begin
            LINK.rx_k_flag_hi <= SIGNAL_ABOVE_MIN;
         end else if (!SIGNAL_ABOVE_MIN) begin
            LINK.rx_word <= 16'hffff;
            LINK.rx_k_flag_lo <= 1'b1;
            LINK.rx_k_flag_hi <= 1'b1;
         end else begin
            LINK.rx_word <= shown_reg[15:0];
            LINK.rx_k_flag_lo <= LINK.prbs_check_en ? prbs_pass_reg : shown_reg[16];
            LINK.rx_k_flag_hi <= shown_reg[17];
         end
      end
   end
endmodule

// File: serdes_word_port_host.sv
// protocol device end of the parallel word port
module serdes_word_port_host (
   // clock, enable, reset
   input wire logic CLK,
   input wire logic CE,
   input wire logic RST,
   // parallel side towards the transceiver
   serdes_link_if.host LINK,
   // configuration
   input wire logic LINK_ENABLE,
   input wire logic TX_ONLY,
   input wire logic PRBS_MODE,
   input wire logic PREEMPH_HIGH,
   // transmit words from the user
   input wire logic [15:0] TX_DATA,
   input wire logic TX_K_LO,
   input wire logic TX_K_HI,
   input wire logic TX_VALID,
   output logic TX_READY,
   // receive words to the user
   output logic [15:0] RX_DATA,
   output logic RX_K_LO,
   output logic RX_K_HI,
   output logic RX_VALID,
   input wire logic RX_READY,
   // status
   output logic PRBS_PASS,
   output logic SIGNAL_PRESENT
);
   logic clk_q_reg;
   logic [14:0] prbs_state_reg;
   logic [30:0] prbs_next;

   assign prbs_next = serdes_pkg::prbs_word(prbs_state_reg);

   // ---------------------------------------------------------------
   // transmit side
   // ---------------------------------------------------------------
   // idle words carry a comma so the far receiver keeps alignment
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         LINK.tx_word <= 16'h0000;
         LINK.tx_k_sel_lo <= 1'b0;
         LINK.tx_k_sel_hi <= 1'b0;
         LINK.ref_clk_run <= 1'b0;
         LINK.enable <= 1'b0;
         LINK.rx_ref_lock_n <= 1'b1;
         LINK.prbs_check_en <= 1'b0;
         LINK.preemph_sel <= 1'b0;
         LINK.factory_test_pin <= 1'b0;
         TX_READY <= 1'b0;
         prbs_state_reg <= serdes_pkg::PRBS_SEED;
      end else if (CE) begin
         LINK.ref_clk_run <= 1'b1;
         LINK.factory_test_pin <= 1'b0;
         LINK.enable <= LINK_ENABLE;
         LINK.rx_ref_lock_n <= !TX_ONLY;
         LINK.prbs_check_en <= PRBS_MODE;
         LINK.preemph_sel <= PREEMPH_HIGH;
         TX_READY <= LINK_ENABLE && !PRBS_MODE;
         if (PRBS_MODE) begin
            LINK.tx_word <= prbs_next[15:0];
            LINK.tx_k_sel_lo <= 1'b0;
            LINK.tx_k_sel_hi <= 1'b0;
            prbs_state_reg <= prbs_next[30:16];
         end else if (TX_VALID && TX_READY) begin
            LINK.tx_word <= TX_DATA;
            LINK.tx_k_sel_lo <= TX_K_LO;
            LINK.tx_k_sel_hi <= TX_K_HI;
         end else begin
            LINK.tx_word <= {8'h00, serdes_pkg::COMMA_BYTE};
            LINK.tx_k_sel_lo <= 1'b1;
            LINK.tx_k_sel_hi <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // receive side
   // ---------------------------------------------------------------
   // words are taken on the word clock rise while the bus is driven
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         clk_q_reg <= 1'b0;
         RX_DATA <= 16'h0000;
         RX_K_LO <= 1'b0;
         RX_K_HI <= 1'b0;
         RX_VALID <= 1'b0;
         PRBS_PASS <= 1'b0;
         SIGNAL_PRESENT <= 1'b0;
         LINK.rx_ready <= 1'b0;
      end else if (CE) begin
         LINK.rx_ready <= RX_READY;
         clk_q_reg <= LINK.rx_word_clk && LINK.rx_word_clk_oe;
         RX_VALID <= LINK.rx_word_clk && LINK.rx_word_clk_oe && !clk_q_reg
                     && LINK.rx_word_oe;
         if (LINK.rx_word_clk && LINK.rx_word_clk_oe && !clk_q_reg && LINK.rx_word_oe) begin
            RX_DATA <= LINK.rx_word;
            RX_K_LO <= LINK.rx_k_flag_lo && !LINK.prbs_check_en;
            RX_K_HI <= LINK.rx_k_flag_hi;
         end
         PRBS_PASS <= LINK.prbs_check_en && LINK.rx_k_flag_lo_oe && LINK.rx_k_flag_lo;
         // a high flag in shutdown means the line still carries signal
         if (!LINK.enable && LINK.rx_k_flag_hi_oe) SIGNAL_PRESENT <= LINK.rx_k_flag_hi;
      end
   end
endmodule

// File: serdes_word_port_sva.sv
// concurrent checks on the parallel word port between the two ends
module serdes_word_port_chk (
   // clock and reset
   input wire logic CLK,
   input wire logic RST,
   // controls driven by the host end
   input wire logic enable,
   input wire logic rx_ref_lock_n,
   input wire logic ref_clk_run,
   input wire logic factory_test_pin,
   // device outputs and their drive enables
   input wire logic rx_word_oe,
   input wire logic rx_word_clk,
   input wire logic rx_word_clk_oe,
   input wire logic rx_k_flag_lo_oe,
   input wire logic rx_k_flag_hi_oe
);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);
   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   // the simulated power-on reset is longer than eight cycles
   a_wclk_low_por: assert property ($rose(enable) |-> !rx_word_clk [*8])
      else $error("word clock active during power-on reset");
   a_word_float_por: assert property ($rose(enable) |-> !rx_word_oe [*8])
      else $error("receive word driven during power-on reset");
   a_off_floats: assert property (!$past(enable) && !enable |->
      !rx_word_oe && !rx_k_flag_lo_oe)
      else $error("receive outputs driven while disabled");
   a_lock_floats: assert property (enable && $past(enable) && !rx_ref_lock_n &&
      !$past(rx_ref_lock_n) |-> !(rx_word_oe || rx_word_clk_oe ||
      rx_k_flag_lo_oe || rx_k_flag_hi_oe))
      else $error("receive side driven while locked to reference");
   a_wclk_one_cycle: assert property (rx_word_clk |=> !rx_word_clk)
      else $error("word clock high longer than one cycle");
   a_wclk_driven: assert property (rx_word_clk |-> rx_word_oe && rx_word_clk_oe)
      else $error("word clock rose while word not driven");
   a_ref_clk_kept: assert property ($past(ref_clk_run) |-> ref_clk_run)
      else $error("reference clock stopped");
   a_test_pin_low: assert property (!factory_test_pin)
      else $error("factory test pin raised");
   a_loss_flag_driven: assert property ($past(ref_clk_run) && !$past(enable) && !enable
      |-> rx_k_flag_hi_oe)
      else $error("loss flag not driven while disabled");
   // main scenarios reached
   cover property ($rose(rx_word_clk));
   cover property ($fell(enable));
   cover property ($fell(rx_ref_lock_n));
endmodule

// File: serdes_word_port_test.sv
// self-checking bench: both ends joined by the link, serial side looped back
module serdes_word_port_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int POR = 20;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic link_enable = 1'b0, tx_only = 1'b0, prbs_mode = 1'b0, preemph_high = 1'b0;
   logic [15:0] tx_data = 16'h0000;
   logic tx_k_lo = 1'b0, tx_k_hi = 1'b0, tx_valid = 1'b0, rx_ready = 1'b1, above_min = 1'b1;
   logic tx_ready, rx_k_lo, rx_k_hi, rx_valid, prbs_pass, sig_present;
   logic ser_out_valid, ser_out_oe, ser_in_ready;
   logic ser_in_valid = 1'b0, corrupt = 1'b0;
   logic [15:0] rx_data;
   logic [19:0] ser_out;
   logic [19:0] ser_in = 20'h00000;
   logic [4:0] pct;
   logic [19:0] sq [$];
   logic [17:0] rq [$];
   int fail_count = 0, checked = 0;

   always #4 clk = ~clk; // 125 MHz reference

   serdes_link_if link ();
   serdes_word_port_dev #(.POR_CYCLES(POR), .BUF_DEPTH(2)) serdes_word_port_dev_i (.CLK(clk),
      .CE(1'b1), .RST(rst), .LINK(link), .SERIAL_OUT(ser_out), .SERIAL_OUT_VALID(ser_out_valid),
      .SERIAL_OUT_OE(ser_out_oe), .PREEMPH_PCT(pct), .SERIAL_IN(ser_in),
      .SERIAL_IN_VALID(ser_in_valid), .SERIAL_IN_READY(ser_in_ready),
      .SIGNAL_ABOVE_MIN(above_min));
   serdes_word_port_host serdes_word_port_host_i (.CLK(clk), .CE(1'b1), .RST(rst), .LINK(link),
      .LINK_ENABLE(link_enable), .TX_ONLY(tx_only), .PRBS_MODE(prbs_mode),
      .PREEMPH_HIGH(preemph_high), .TX_DATA(tx_data), .TX_K_LO(tx_k_lo), .TX_K_HI(tx_k_hi),
      .TX_VALID(tx_valid), .TX_READY(tx_ready), .RX_DATA(rx_data), .RX_K_LO(rx_k_lo),
      .RX_K_HI(rx_k_hi), .RX_VALID(rx_valid), .RX_READY(rx_ready), .PRBS_PASS(prbs_pass),
      .SIGNAL_PRESENT(sig_present));
   serdes_word_port_chk serdes_word_port_chk_i (.CLK(clk), .RST(rst), .enable(link.enable),
      .rx_ref_lock_n(link.rx_ref_lock_n), .ref_clk_run(link.ref_clk_run),
      .factory_test_pin(link.factory_test_pin), .rx_word_oe(link.rx_word_oe),
      .rx_word_clk(link.rx_word_clk), .rx_word_clk_oe(link.rx_word_clk_oe),
      .rx_k_flag_lo_oe(link.rx_k_flag_lo_oe), .rx_k_flag_hi_oe(link.rx_k_flag_hi_oe));

   // serial loopback; comma idles are dropped so the slower receive side is not flooded
   always @(posedge clk) begin
      if (ser_in_valid && ser_in_ready && sq.size() != 0) void'(sq.pop_front());
      if (ser_out_valid && ser_out[9:0] != 10'h0fa && ser_out[9:0] != 10'h305)
         sq.push_back(corrupt ? {ser_out[19:10], 10'h000} : ser_out);
      ser_in_valid <= (sq.size() != 0);
      if (sq.size() != 0) ser_in <= sq[0];
      if (rx_valid) rq.push_back({rx_k_hi, rx_k_lo, rx_data});
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic close_out;
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic cycles(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic wait_run(output int n);
      n = 0;
      while (link.rx_word_oe !== 1'b1 && n < 200) begin
         @(posedge clk);
         n++;
      end
   endtask

   // stalled receiver: words wait in the buffer, then arrive whole and in order
   task automatic t_words;
      logic [17:0] w [4];
      int n;
      w = '{18'h01234, 18'h2bc5a, 18'h10f1c, 18'h3fcfc};
      @(negedge clk);
      sq.delete();
      rq.delete();
      check("idle lo", 32'(ser_out[9:0] == 10'h0fa || ser_out[9:0] == 10'h305), 32'h1);
      check("idle hi", 32'(ser_out[19:10] == 10'h274 || ser_out[19:10] == 10'h18b), 32'h1);
      @(posedge clk);
      rx_ready <= 1'b0;
      foreach (w[i]) begin
         {tx_k_hi, tx_k_lo, tx_data} <= w[i];
         tx_valid <= 1'b1;
         do @(posedge clk); while (tx_ready !== 1'b1);
      end
      tx_valid <= 1'b0;
      cycles(20);
      @(negedge clk);
      check("stall ready", 32'(ser_in_ready), 32'h0);
      @(posedge clk);
      rx_ready <= 1'b1;
      for (n = 0; n < 200 && rq.size() < 4; n++) @(posedge clk);
      // a missing word shows up as zero against the expected pattern
      while (rq.size() < 4) rq.push_back(18'h0);
      foreach (w[i]) begin
         check("rx word", 32'(rq[i]), 32'(w[i]));
      end
      $display("words test done");
   endtask

   task automatic t_preemph;
      for (int p = 0; p < 2; p++) begin
         @(posedge clk);
         preemph_high <= p[0];
         cycles(4);
         @(negedge clk);
         check("preemph", 32'(pct), p ? 32'h14 : 32'h05);
      end
      $display("preemph test done");
   endtask

   task automatic t_loss;
      @(posedge clk);
      above_min <= 1'b0;
      cycles(3);
      @(negedge clk);
      check("loss word", 32'(link.rx_word), 32'hffff);
      check("loss flags", 32'({link.rx_k_flag_lo, link.rx_k_flag_hi}), 32'h3);
      @(posedge clk);
      above_min <= 1'b1;
      cycles(4);
      $display("loss test done");
   endtask

   // pass on a clean pattern, fail once symbols are damaged
   task automatic t_prbs;
      @(posedge clk);
      prbs_mode <= 1'b1;
      cycles(60);
      @(negedge clk);
      check("prbs pass", 32'(prbs_pass), 32'h1);
      check("prbs flag", 32'(link.rx_k_flag_lo), 32'h1);
      sq.delete();
      corrupt = 1'b1;
      cycles(30);
      @(negedge clk);
      check("prbs fail", 32'(link.rx_k_flag_lo), 32'h0);
      corrupt = 1'b0;
      @(posedge clk);
      prbs_mode <= 1'b0;
      cycles(4);
      // drop queued pattern words so later scenarios start from an empty line
      @(negedge clk);
      sq.delete();
      cycles(8);
      $display("prbs test done");
   endtask

   task automatic t_tx_only;
      @(posedge clk);
      tx_only <= 1'b1;
      cycles(4);
      @(negedge clk);
      check("lock low", 32'(link.rx_ref_lock_n), 32'h0);
      check("rx oe", 32'({link.rx_word_oe, link.rx_word_clk_oe, link.rx_k_flag_lo_oe,
         link.rx_k_flag_hi_oe}), 32'h0);
      check("tx runs", 32'(ser_out_valid), 32'h1);
      @(posedge clk);
      tx_only <= 1'b0;
      cycles(4);
      $display("tx only test done");
   endtask

   task automatic t_shutdown;
      int n;
      @(posedge clk);
      link_enable <= 1'b0;
      cycles(4);
      @(negedge clk);
      check("off oe", 32'({link.rx_word_oe, link.rx_k_flag_lo_oe, ser_out_oe}), 32'h0);
      check("loss flag", 32'(link.rx_k_flag_hi), 32'h1);
      check("present", 32'(sig_present), 32'h1);
      @(posedge clk);
      above_min <= 1'b0;
      cycles(4);
      @(negedge clk);
      check("loss flag", 32'(link.rx_k_flag_hi), 32'h0);
      check("present", 32'(sig_present), 32'h0);
      @(posedge clk);
      above_min <= 1'b1;
      link_enable <= 1'b1;
      wait_run(n);
      check("por length", 32'(n >= POR && n < 200), 32'h1);
      $display("shutdown test done");
   endtask

   initial begin
      int n;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      link_enable <= 1'b1;
      wait_run(n);
      t_words;
      t_preemph;
      t_loss;
      t_prbs;
      t_tx_only;
      t_shutdown;
      t_words;
      close_out;
   end

   // hang guard, far beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      close_out;
   end
endmodule
